// file: verilog/chpc_consts.svh
// Constants of the charger high-impedance, output-mode and power-path control block.
// Assumes a 40 MHz hclk and word-aligned AHB-Lite register offsets.
`ifndef CHPC_CONSTS_SVH
`define CHPC_CONSTS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define CHPC_ADDR_CTRL     8'h00
`define CHPC_ADDR_TARGET   8'h04
`define CHPC_ADDR_SYSMIN   8'h08
`define CHPC_ADDR_TSLIM    8'h0c
`define CHPC_ADDR_STATUS   8'h10
`define CHPC_ADDR_FLAG     8'h14
`define CHPC_ADDR_MASK     8'h18

// ****************************************
// Control register fields
// ****************************************
`define CHPC_CTRL_HIZ      0
`define CHPC_CTRL_ADC      1
`define CHPC_CTRL_OTG      2
`define CHPC_CTRL_PATH1    3
`define CHPC_CTRL_PATH2    4
`define CHPC_CTRL_DRVDIS   5
`define CHPC_CTRL_PFMDIS   6
`define CHPC_CTRL_OOADIS   7
`define CHPC_CTRL_CHGEN    8
`define CHPC_CTRL_LIM_LO   9
`define CHPC_CTRL_LIM_HI   10
`define CHPC_TGT_V_HI      10
`define CHPC_TGT_I_LO      16
`define CHPC_TGT_I_HI      22

// ****************************************
// Reset values
// ****************************************
`define CHPC_CTRL_RST      32'h0000_0600
`define CHPC_TGT_RST       32'h0000_0000
`define CHPC_TSLIM_RST     16'hd030
`define CHPC_MASK_RST      4'h0

// ****************************************
// Discharge limits and timing
// ****************************************
`define CHPC_LIM_3A_MA     13'h0bb8
`define CHPC_LIM_4A_MA     13'h0fa0
`define CHPC_LIM_5A_MA     13'h1388
`define CHPC_CLK_MHZ       40
`define CHPC_START_DELAY_US 5000
`define CHPC_START_DELAY_CYC (`CHPC_START_DELAY_US * `CHPC_CLK_MHZ)

`endif

// file: verilog/chpc_pkg.sv
// Types shared by the control block, its checker and the bench.
// Assumes nothing beyond a SystemVerilog compiler.
package chpc_pkg;

  // ****************************************
  // Sensed analog conditions, pin side
  // ****************************************
  typedef struct packed {
    logic input_overvoltage_fault;
    logic system_overvoltage_fault;
    logic battery_overvoltage_fault;
    logic output_mode_overvoltage_fault;
    logic system_short_fault;
    logic input_overcurrent_fault;
    logic battery_above_otg;
    logic input_below_uvlo;
    logic discharge_over_limit;
    logic battery_below_minsys;
    logic charge_terminated;
    logic pfm_active;
  } chpc_sense_t;

  // Output-mode start sequence
  typedef enum logic [1:0] {
    CHPC_OTG_IDLE  = 2'b00,
    CHPC_OTG_DELAY = 2'b01,
    CHPC_OTG_PATH  = 2'b10,
    CHPC_OTG_RUN   = 2'b11
  } chpc_otg_state_t;

  // System regulation target
  typedef enum logic [1:0] {
    CHPC_SYS_MIN_PLUS_200 = 2'b00,
    CHPC_SYS_BAT_PLUS_200 = 2'b01,
    CHPC_SYS_BAT_PLUS_600 = 2'b10,
    CHPC_SYS_BAT_FET_DROP = 2'b11
  } chpc_sysreg_t;

endpackage

// file: verilog/chpc_sync.sv
// Three-stage synchroniser for asynchronous pin-side levels.
// Assumes each bit is an independent slow level; a change is taken when stages two and three agree.
`timescale 1ns/10ps

module chpc_sync #(
  parameter int          WIDTH = 12,
  parameter logic [WIDTH-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic             hclk,
  input  wire logic             hresetn,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;

  // Stage one is only read by stage two
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage1 <= RST;
      stage2 <= RST;
      stage3 <= RST;
    end else begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign agree = ~(stage2 ^ stage3);

  // Hold last value while the last two stages still differ
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync_out <= RST;
    end else begin
      sync_out <= (stage3 & agree) | (sync_out & ~agree);
    end
  end

endmodule

// file: verilog/chpc_ctrl.sv
// Charger control: high-impedance state, battery-powered output mode and power path status.
// Assumes an AHB-Lite master on hclk, analog comparators on the sense pins, straps stable at reset.
`timescale 1ns/10ps
`include "chpc_consts.svh"

module chpc_ctrl
  import chpc_pkg::*;
#(
  parameter int START_DELAY_CYC = `CHPC_START_DELAY_CYC
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Sense pins and same-clock ADC reading
  input  wire chpc_sense_t sense_in,
  input  wire logic [7:0]  ts_reading,
  // Straps
  input  wire logic        path1_switch_present_pin,
  input  wire logic        path2_switch_present_pin,
  input  wire logic [7:0]  programming_pin_code,
  // Power stage controls
  output logic             internal_regulator,
  output logic             converter_switching,
  output logic             adc_on,
  output logic             battery_switch,
  output logic             battery_switch_linear,
  output logic             path1_drive,
  output logic             path2_drive,
  output logic [10:0]      output_mode_voltage_target,
  output logic [6:0]       output_mode_current_cmd,
  output logic             pfm_allowed,
  output logic             audio_avoid_on,
  output logic [12:0]      discharge_limit_ma,
  output logic             soft_start,
  output logic [7:0]       minimum_system_voltage,
  output chpc_sysreg_t     system_regulation_mode,
  // Interrupt
  output logic             irq,
  output logic             int_pulse
);

  localparam int CW = $clog2(START_DELAY_CYC + 1);

  // ****************************************
  // Decoders
  // ****************************************
  function automatic logic [12:0] limit_ma(input logic [1:0] code);
    unique case (code)
      2'b00: limit_ma = `CHPC_LIM_3A_MA;
      2'b01: limit_ma = `CHPC_LIM_4A_MA;
      2'b10: limit_ma = `CHPC_LIM_5A_MA;
      2'b11: limit_ma = 13'h0000;
    endcase
  endfunction

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a[7:2] == off[7:2]);
  endfunction

  // ****************************************
  // Storage and wires
  // ****************************************
  chpc_sense_t      sense;
  chpc_otg_state_t  otg_state;
  chpc_otg_state_t  next_otg_state;
  logic [31:0]      ctrl;
  logic [31:0]      target;
  logic [15:0]      ts_limit;
  logic [3:0]       flag;
  logic [3:0]       mask;
  logic [3:0]       event_vec;
  logic [CW-1:0]    delay_cnt;
  logic             path1_present;
  logic             path2_present;
  logic             strap_done;
  logic             wr_pend;
  logic [7:0]       wr_addr;
  logic             disch_status;
  logic             disch_status_q;
  logic             ov_q;
  logic             high_impedance_state;
  logic             ov_fault;
  logic             hiz_fault;
  logic             otg_ok;
  logic             direct_start;
  logic             path_ok;
  logic             limit_on;
  logic             run;
  logic             addr_valid;
  logic [31:0]      status_word;

  // Pin-side comparators cross into hclk
  chpc_sync #(
    .WIDTH ($bits(chpc_sense_t)),
    .RST   ('0)
  ) u_sync (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .async_in (sense_in),
    .sync_out (sense)
  );

  // Decoded control fields
  assign high_impedance_state          = ctrl[`CHPC_CTRL_HIZ];
  assign limit_on     = (ctrl[`CHPC_CTRL_LIM_HI:`CHPC_CTRL_LIM_LO] != 2'b11);
  assign run          = (otg_state == CHPC_OTG_RUN);
  assign ov_fault     = sense.input_overvoltage_fault | sense.system_overvoltage_fault |
                        sense.battery_overvoltage_fault | sense.output_mode_overvoltage_fault;
  assign hiz_fault    = sense.system_short_fault | sense.input_overcurrent_fault;
  assign otg_ok       = sense.battery_above_otg & ~sense.battery_overvoltage_fault &
                        sense.input_below_uvlo & (ts_reading >= ts_limit[7:0]) &
                        (ts_reading <= ts_limit[15:8]) & ~high_impedance_state;
  assign direct_start = ~(path1_present | path2_present) | ctrl[`CHPC_CTRL_DRVDIS];
  // Populated path enabled; both at once is ignored
  assign path_ok      = ((path1_present & ctrl[`CHPC_CTRL_PATH1]) |
                         (path2_present & ctrl[`CHPC_CTRL_PATH2])) &
                        ~(ctrl[`CHPC_CTRL_PATH1] & ctrl[`CHPC_CTRL_PATH2]);

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  // Zero wait state, always OKAY
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign addr_valid = hsel & htrans[1] & hready;

  // Write address is held for the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
    end else begin
      wr_pend <= addr_valid & hwrite;
      wr_addr <= haddr;
    end
  end

  assign status_word = {21'h000000, sense.charge_terminated, battery_switch, converter_switching,
                        path2_present, path1_present, otg_state, run,
                        sense.battery_below_minsys, disch_status, high_impedance_state};

  // Read data captured at the address phase, standing in the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (addr_valid & ~hwrite) begin
      if (addr_is(haddr, `CHPC_ADDR_CTRL))        hrdata <= ctrl;
      else if (addr_is(haddr, `CHPC_ADDR_TARGET)) hrdata <= target;
      else if (addr_is(haddr, `CHPC_ADDR_SYSMIN)) hrdata <= {24'h000000, minimum_system_voltage};
      else if (addr_is(haddr, `CHPC_ADDR_TSLIM))  hrdata <= {16'h0000, ts_limit};
      else if (addr_is(haddr, `CHPC_ADDR_STATUS)) hrdata <= status_word;
      else if (addr_is(haddr, `CHPC_ADDR_FLAG))   hrdata <= {28'h0000000, flag};
      else if (addr_is(haddr, `CHPC_ADDR_MASK))   hrdata <= {28'h0000000, mask};
      else                                        hrdata <= 32'h0000_0000;
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  // Host writes, with hardware entry into the high-impedance state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= `CHPC_CTRL_RST;
    end else begin
      if (wr_pend && addr_is(wr_addr, `CHPC_ADDR_CTRL)) begin
        ctrl <= {21'h000000, hwdata[10:0]};
      end else if (hiz_fault && !high_impedance_state) begin
        ctrl[`CHPC_CTRL_ADC] <= 1'b0;
      end
      // Fault sets enable, wins over host clear
      if (hiz_fault) begin
        ctrl[`CHPC_CTRL_HIZ] <= 1'b1;
      end
      // Host entry also drops the ADC unless set in the same write
      if (wr_pend && addr_is(wr_addr, `CHPC_ADDR_CTRL) && hwdata[`CHPC_CTRL_HIZ] && !high_impedance_state &&
          !hwdata[`CHPC_CTRL_ADC]) begin
        ctrl[`CHPC_CTRL_ADC] <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      target   <= `CHPC_TGT_RST;
      ts_limit <= `CHPC_TSLIM_RST;
    end else if (wr_pend) begin
      if (addr_is(wr_addr, `CHPC_ADDR_TARGET)) begin
        target <= {9'h000, hwdata[`CHPC_TGT_I_HI:`CHPC_TGT_I_LO], 5'h00, hwdata[`CHPC_TGT_V_HI:0]};
      end
      if (addr_is(wr_addr, `CHPC_ADDR_TSLIM)) begin
        ts_limit <= hwdata[15:0];
      end
    end
  end

  // Straps caught once after reset release; host may override the minimum system voltage only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done             <= 1'b0;
      minimum_system_voltage <= 8'h00;
      path1_present          <= 1'b0;
      path2_present          <= 1'b0;
    end else if (!strap_done) begin
      strap_done             <= 1'b1;
      minimum_system_voltage <= programming_pin_code;
      path1_present          <= path1_switch_present_pin;
      path2_present          <= path2_switch_present_pin;
    end else if (wr_pend && addr_is(wr_addr, `CHPC_ADDR_SYSMIN)) begin
      minimum_system_voltage <= hwdata[7:0];
    end
  end

  // ****************************************
  // Output-mode start sequence
  // ****************************************
  always_comb begin
    next_otg_state = otg_state;
    unique case (otg_state)
      CHPC_OTG_IDLE: begin
        if (ctrl[`CHPC_CTRL_OTG] && otg_ok) begin
          next_otg_state = direct_start ? CHPC_OTG_DELAY : CHPC_OTG_PATH;
        end
      end
      CHPC_OTG_DELAY: begin
        if (!(ctrl[`CHPC_CTRL_OTG] && otg_ok)) begin
          next_otg_state = CHPC_OTG_IDLE;
        end else if (delay_cnt == CW'(START_DELAY_CYC - 1)) begin
          next_otg_state = CHPC_OTG_RUN;
        end
      end
      CHPC_OTG_PATH: begin
        if (!(ctrl[`CHPC_CTRL_OTG] && otg_ok)) begin
          next_otg_state = CHPC_OTG_IDLE;
        end else if (path_ok) begin
          next_otg_state = CHPC_OTG_RUN;
        end
      end
      CHPC_OTG_RUN: begin
        if (!(ctrl[`CHPC_CTRL_OTG] && otg_ok)) begin
          next_otg_state = CHPC_OTG_IDLE;
        end else if (!direct_start && !path_ok) begin
          // Path cleared: stop and wait for the other
          next_otg_state = CHPC_OTG_PATH;
        end
      end
    endcase
  end

  // Delay counts only while waiting to start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      otg_state <= CHPC_OTG_IDLE;
      delay_cnt <= '0;
    end else begin
      otg_state <= next_otg_state;
      delay_cnt <= (otg_state == CHPC_OTG_DELAY) ? delay_cnt + CW'(1) : '0;
    end
  end

  // ****************************************
  // Discharge limiting
  // ****************************************
  // Status follows the comparator while running with a discharge limit set
  // Clears itself once current is below the limit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disch_status   <= 1'b0;
      disch_status_q <= 1'b0;
      ov_q           <= 1'b0;
    end else begin
      disch_status   <= run & limit_on & sense.discharge_over_limit;
      disch_status_q <= disch_status;
      ov_q           <= ov_fault;
    end
  end

  // Back off current while over; ramp up only with soft-start
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      output_mode_current_cmd <= 7'h00;
    end else if (!run) begin
      output_mode_current_cmd <= 7'h00;
    end else if (disch_status) begin
      if (output_mode_current_cmd != 7'h00) begin
        output_mode_current_cmd <= output_mode_current_cmd - 7'h01;
      end
    end else if (!limit_on) begin
      output_mode_current_cmd <= target[`CHPC_TGT_I_HI:`CHPC_TGT_I_LO];
    end else if (output_mode_current_cmd < target[`CHPC_TGT_I_HI:`CHPC_TGT_I_LO]) begin
      output_mode_current_cmd <= output_mode_current_cmd + 7'h01;
    end else begin
      output_mode_current_cmd <= target[`CHPC_TGT_I_HI:`CHPC_TGT_I_LO];
    end
  end

  // ****************************************
  // Interrupt flags
  // ****************************************
  // Bit 0 discharge limit, 1 fault high-impedance, 2 output mode start, 3 overvoltage stop
  assign event_vec = {ov_fault & ~ov_q,
                      (otg_state != CHPC_OTG_RUN) & (next_otg_state == CHPC_OTG_RUN),
                      hiz_fault & ~high_impedance_state,
                      disch_status & ~disch_status_q};

  // Flags set only while unmasked; set wins over write-one clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag <= 4'h0;
      mask <= `CHPC_MASK_RST;
    end else begin
      if (wr_pend && addr_is(wr_addr, `CHPC_ADDR_MASK)) begin
        mask <= hwdata[3:0];
      end
      if (wr_pend && addr_is(wr_addr, `CHPC_ADDR_FLAG)) begin
        flag <= (flag & ~hwdata[3:0]) | (event_vec & ~mask);
      end else begin
        flag <= flag | (event_vec & ~mask);
      end
    end
  end

  // Pulse on every event, level while unmasked flags stand
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_pulse <= 1'b0;
      irq       <= 1'b0;
    end else begin
      int_pulse <= |event_vec;
      irq       <= |(flag & ~mask);
    end
  end

  // ****************************************
  // Power stage outputs
  // ****************************************
  // Registered so the analog side never sees decode glitches
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_regulator         <= 1'b0;
      converter_switching        <= 1'b0;
      adc_on                     <= 1'b0;
      path1_drive                <= 1'b0;
      path2_drive                <= 1'b0;
      output_mode_voltage_target <= 11'h000;
      pfm_allowed                <= 1'b1;
      audio_avoid_on             <= 1'b1;
      discharge_limit_ma         <= 13'h0000;
      soft_start                 <= 1'b0;
    end else begin
      // Regulator off in the high-impedance state
      internal_regulator         <= ~high_impedance_state;
      // No switching in high impedance or on overvoltage
      converter_switching        <= ~high_impedance_state & ~ov_fault & (ctrl[`CHPC_CTRL_OTG] ? run : 1'b1);
      // ADC follows its enable, cleared on entry unless a same-cycle control write sets it
      adc_on                     <= ctrl[`CHPC_CTRL_ADC];
      // Both path bits together drive neither switch
      path1_drive                <= run & ~direct_start & path_ok & ctrl[`CHPC_CTRL_PATH1];
      path2_drive                <= run & ~direct_start & path_ok & ctrl[`CHPC_CTRL_PATH2];
      output_mode_voltage_target <= target[`CHPC_TGT_V_HI:0];
      pfm_allowed                <= run ? ~ctrl[`CHPC_CTRL_PFMDIS] : 1'b1;
      audio_avoid_on             <= run ? ~ctrl[`CHPC_CTRL_OOADIS] : 1'b1;
      discharge_limit_ma         <= limit_ma(ctrl[`CHPC_CTRL_LIM_HI:`CHPC_CTRL_LIM_LO]);
      soft_start                 <= limit_on;
    end
  end

  // System regulation and battery switch
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      battery_switch         <= 1'b1;
      battery_switch_linear  <= 1'b0;
      system_regulation_mode <= CHPC_SYS_BAT_FET_DROP;
    end else begin
      // On in high impedance; off after termination
      battery_switch        <= high_impedance_state | ~sense.charge_terminated;
      battery_switch_linear <= sense.battery_below_minsys & ~high_impedance_state;
      if (sense.battery_below_minsys) begin
        system_regulation_mode <= CHPC_SYS_MIN_PLUS_200;
      end else if (!ctrl[`CHPC_CTRL_CHGEN] || sense.charge_terminated) begin
        system_regulation_mode <= sense.pfm_active ? CHPC_SYS_BAT_PLUS_600 : CHPC_SYS_BAT_PLUS_200;
      end else begin
        system_regulation_mode <= CHPC_SYS_BAT_FET_DROP;
      end
    end
  end

endmodule

// file: test/chpc_props.sv
// Checker of the charger control outputs against power state relations.
// Sees only chpc_ctrl ports; the bind stands at the foot of this file.
`timescale 1ns/10ps
`include "chpc_consts.svh"
module chpc_props
  import chpc_pkg::*;
(
  // Clock, reset and sensed levels
  input wire logic         hclk,
  input wire logic         hresetn,
  input wire chpc_sense_t  sense_in,
  // Power stage controls
  input wire logic         internal_regulator,
  input wire logic         converter_switching,
  input wire logic         battery_switch,
  input wire logic         battery_switch_linear,
  input wire logic         path1_drive,
  input wire logic         path2_drive,
  input wire logic [12:0]  discharge_limit_ma,
  input wire logic         soft_start,
  input wire chpc_sysreg_t system_regulation_mode
);
  // ****
  // Assertions
  // ****
  // Sense levels pass a three-stage synchroniser, hence the long runs below
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  hiz_stop_a: assert property (!internal_regulator |-> !converter_switching)
    else $error("switching with regulator off");
  hiz_batt_a: assert property (!internal_regulator |-> battery_switch)
    else $error("battery switch off in high impedance");
  ov_stop_a: assert property (sense_in.input_overvoltage_fault [*7] |-> !converter_switching)
    else $error("switching during overvoltage");
  short_hiz_a: assert property (sense_in.system_short_fault [*8] |-> !internal_regulator)
    else $error("short fault left regulator on");
  limit_code_a: assert property (discharge_limit_ma inside
    {13'h0, `CHPC_LIM_3A_MA, `CHPC_LIM_4A_MA, `CHPC_LIM_5A_MA}) else $error("bad discharge limit");
  soft_start_a: assert property (soft_start == (discharge_limit_ma != 13'h0))
    else $error("soft start mismatch");
  linear_min_a: assert property (battery_switch_linear |-> system_regulation_mode == CHPC_SYS_MIN_PLUS_200)
    else $error("linear mode without minimum regulation");
  one_path_a: assert property (!(path1_drive && path2_drive))
    else $error("both paths driven");
endmodule
bind chpc_ctrl chpc_props i_props (.*);

// file: test/chpc_host.sv
// Host model: AHB-Lite master making single word transfers.
// Assumes one slave whose hreadyout returns as hready.
`timescale 1ns/10ps
module chpc_host (
  // Bus
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel = 1'b0,
  output logic [7:0]       haddr = 8'h00,
  output logic [1:0]       htrans = 2'h0,
  output logic             hwrite = 1'b0,
  output logic [2:0]       hsize = 3'h2,
  output logic [31:0]      hwdata = 32'h0
);
  // ****
  // Transfers
  // ****
  bit tmo = 0;
  // Bounded wait; a slave that never answers marks a timeout
  task automatic rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (hready !== 1'b1) tmo = 1;
  endtask
  // Called just after an edge; hwdata is inverted in each read data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    htrans <= 2'h0;
    hwdata <= w ? d : ~hwdata;
    rdy();
    q = hrdata;
  endtask
endmodule

// file: test/chpc_ctrl_bench.sv
// Bench for chpc_ctrl: register calls, sense levels and strap resets.
// Assumes the host model and checker files are compiled alongside.
`timescale 1ns/10ps
`include "chpc_consts.svh"
module chpc_ctrl_bench
  import chpc_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, int_pulse, soft_start, adc_on, battery_switch;
  logic internal_regulator, converter_switching, battery_switch_linear, path1_drive, path2_drive;
  logic pfm_allowed, audio_avoid_on, path1_switch_present_pin, path2_switch_present_pin;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] haddr, ts_reading, programming_pin_code, minimum_system_voltage;
  logic [31:0] hwdata, hrdata, q;
  logic [10:0] output_mode_voltage_target;
  logic [6:0] output_mode_current_cmd;
  logic [12:0] discharge_limit_ma;
  logic [12:0] lim [4] = '{`CHPC_LIM_3A_MA, `CHPC_LIM_4A_MA, `CHPC_LIM_5A_MA, 13'h0};
  chpc_sense_t sense_in;
  chpc_sysreg_t system_regulation_mode;
  int error_cnt = 0, total_checks = 0, pulses = 0;
  // ****
  // Design, host and helpers
  // ****
  // Short start delay keeps the run brief
  chpc_ctrl #(.START_DELAY_CYC(20)) i_dut (.hready(hreadyout), .*);
  chpc_host i_host (.hready(hreadyout), .*);
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  always @(posedge hclk) if (int_pulse === 1'b1) pulses++;
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge hclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    i_host.xfer(1'b0, a, 32'h0, q);
    chk($sformatf("reg %h", a), e, q & m);
  endtask
  // Straps are held steady across the release edge
  task automatic rst(input logic s1, input logic s2);
    hresetn <= 1'b0;
    path1_switch_present_pin <= s1;
    path2_switch_present_pin <= s2;
    w(8);
    hresetn <= 1'b1;
    w(1);
  endtask
  task automatic end_sim();
    if (i_host.tmo) error_cnt++;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    w(20000);
    error_cnt++;
    end_sim();
  end
  // ****
  // Scenarios
  // ****
  initial begin
    hresetn = 1'b0;
    sense_in = '0;
    ts_reading = 8'h80;
    programming_pin_code = 8'h5a;
    rst(1'b0, 1'b0);
    rd(`CHPC_ADDR_CTRL, '1, `CHPC_CTRL_RST);
    rd(`CHPC_ADDR_TSLIM, '1, {16'h0, `CHPC_TSLIM_RST});
    rd(`CHPC_ADDR_MASK, '1, 32'h0);
    rd(`CHPC_ADDR_SYSMIN, 32'hff, 32'h5a);
    wr(8'h1c, '1);
    rd(8'h1c, '1, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(`CHPC_ADDR_CTRL, 32'(c) << 9);
      w(3);
      chk("limit", lim[c], discharge_limit_ma);
      chk("soft", c != 3, soft_start);
    end
    wr(`CHPC_ADDR_TARGET, 32'h007f_07ff);
    wr(`CHPC_ADDR_SYSMIN, 32'h33);
    w(3);
    chk("vtarget", 32'h7ff, output_mode_voltage_target);
    chk("sysmin", 32'h33, minimum_system_voltage);
    wr(`CHPC_ADDR_CTRL, 32'h601);
    w(3);
    chk("hiz", 32'h1, {internal_regulator, converter_switching, adc_on, battery_switch} );
    wr(`CHPC_ADDR_CTRL, 32'h603);
    w(3);
    chk("adc", 1, adc_on);
    wr(`CHPC_ADDR_CTRL, 32'h600);
    sense_in.system_short_fault <= 1'b1;
    w(10);
    sense_in.system_short_fault <= 1'b0;
    w(6);
    rd(`CHPC_ADDR_CTRL, 32'h1, 32'h1);
    wr(`CHPC_ADDR_CTRL, 32'h600);
    sense_in.input_overvoltage_fault <= 1'b1;
    w(10);
    chk("ov", 32'h2, {internal_regulator, converter_switching});
    sense_in.input_overvoltage_fault <= 1'b0;
    sense_in.battery_below_minsys <= 1'b1;
    w(8);
    chk("linear", 1, battery_switch_linear);
    rd(`CHPC_ADDR_STATUS, 32'h4, 32'h4);
    sense_in.battery_below_minsys <= 1'b0;
    w(8);
    chk("sysreg", CHPC_SYS_BAT_PLUS_200, system_regulation_mode);
    sense_in.pfm_active <= 1'b1;
    w(8);
    chk("sysreg", CHPC_SYS_BAT_PLUS_600, system_regulation_mode);
    sense_in.pfm_active <= 1'b0;
    sense_in.charge_terminated <= 1'b1;
    w(8);
    chk("batsw", 0, battery_switch);
    sense_in.charge_terminated <= 1'b0;
    sense_in.battery_above_otg <= 1'b1;
    sense_in.input_below_uvlo <= 1'b1;
    ts_reading <= 8'hff;
    w(8);
    wr(`CHPC_ADDR_CTRL, 32'h604);
    w(40);
    rd(`CHPC_ADDR_STATUS, 32'h8, 32'h0);
    ts_reading <= 8'h80;
    w(3);
    rd(`CHPC_ADDR_STATUS, 32'h38, 32'h10);
    w(25);
    rd(`CHPC_ADDR_STATUS, 32'h38, 32'h38);
    wr(`CHPC_ADDR_CTRL, 32'h0c4);
    w(3);
    chk("pfm ooa", 0, {pfm_allowed, audio_avoid_on});
    wr(`CHPC_ADDR_FLAG, 32'hf);
    pulses = 0;
    sense_in.discharge_over_limit <= 1'b1;
    w(12);
    chk("irq", 1, irq);
    chk("pulse", 1, pulses != 0);
    chk("cur", 1, output_mode_current_cmd < 7'h7f);
    rd(`CHPC_ADDR_STATUS, 32'h2, 32'h2);
    sense_in.discharge_over_limit <= 1'b0;
    w(10);
    rd(`CHPC_ADDR_STATUS, 32'h2, 32'h0);
    rd(`CHPC_ADDR_FLAG, 32'h1, 32'h1);
    wr(`CHPC_ADDR_FLAG, 32'h1);
    wr(`CHPC_ADDR_MASK, 32'h1);
    pulses = 0;
    sense_in.discharge_over_limit <= 1'b1;
    w(12);
    rd(`CHPC_ADDR_FLAG, 32'h1, 32'h0);
    chk("masked", 32'h1, {irq, pulses != 0});
    sense_in.discharge_over_limit <= 1'b0;
    rst(1'b1, 1'b1);
    wr(`CHPC_ADDR_CTRL, 32'h604);
    w(30);
    rd(`CHPC_ADDR_STATUS, 32'h138, 32'h20);
    wr(`CHPC_ADDR_CTRL, 32'h60c);
    w(4);
    chk("path1", 32'h6, {converter_switching, path1_drive, path2_drive});
    wr(`CHPC_ADDR_CTRL, 32'h604);
    w(3);
    chk("swap", 0, converter_switching);
    wr(`CHPC_ADDR_CTRL, 32'h614);
    w(4);
    chk("path2", 32'h5, {converter_switching, path1_drive, path2_drive});
    wr(`CHPC_ADDR_CTRL, 32'h61c);
    w(4);
    chk("both", 0, {converter_switching, path1_drive, path2_drive});
    end_sim();
  end
endmodule
